// [rtl/asc_pkg.sv]
package asc_pkg;
   // APB register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] CTRL3_OFF = 8'h04;
   localparam logic [7:0] RES_LOW_OFF = 8'h08;
   localparam logic [7:0] RES_HIGH_OFF = 8'h0C;
   localparam logic [7:0] STATUS_OFF = 8'h10;
   localparam logic [7:0] MASK_OFF = 8'h14;
   // Control register fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_START_BIT = 1;
   localparam int CTRL_LEFT_BIT = 2;
   localparam int CTRL_DIFF_BIT = 3;
   localparam int CTRL_IE_BIT = 4;
   localparam int CTRL_PRESC_LSB = 8;
   localparam int PRESC_W = 3;
   // Status bits
   localparam int ST_DONE_BIT = 0;
   localparam int ST_SLEEP_BIT = 1;
   localparam int IRQ_W = 2;
   // Sleep mode codes on the sleep controller input
   localparam logic [2:0] SLEEP_IDLE = 3'h0;
   localparam logic [2:0] SLEEP_NOISE = 3'h1;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MIN_TRACK_NS = 500;
   localparam int MIN_TRACK_CYC = (MIN_TRACK_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int CONV_CLKS = 11;
   localparam int RES_W = 10;
   localparam logic [RES_W-1:0] SE_MAX = 10'h3FF;
   localparam logic [RES_W-1:0] DIFF_MIN = 10'h200;
   localparam logic [RES_W-1:0] DIFF_MAX = 10'h1FF;
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   typedef enum logic [2:0] {S_IDLE, S_TRACK, S_CONV, S_DONE} asc_state_t;
endpackage : asc_pkg

// [rtl/asc_conv_ctrl.sv]
// Functional notes
// RULE_01 - Sleep start conversion when CPU halts
// RULE_02 - Sleep conversion end wakes CPU interrupt
// RULE_03 - Other wake still gets done request
// RULE_04 - No automatic return to sleep
// RULE_05 - Deep sleep leaves converter powered
// RULE_06 - Single-ended tracking at least 500ns
// RULE_07 - Tracking lengthened by two-bit field
// RULE_08 - Differential sample is half clock
// RULE_09 - Completion sets flag, loads result
// RULE_10 - Single-ended unsigned code, clamp 0x3FF
// RULE_11 - Differential two's complement, saturates
// RULE_12 - Sign in top result bit
// RULE_13 - Left adjust moves bits to high
// RULE_14 - Result bytes update together only
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module asc_conv_ctrl
   import asc_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   input wire logic [31:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [DATA_W-1:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic i_cpu_halted,
   input wire logic [2:0] i_sleep_mode,
   input wire logic [11:0] i_analog_code,
   output logic [DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_irq,
   output logic o_converter_enable,
   output logic o_sample_switch,
   output logic o_secondary_conversion_clock,
   output logic o_busy
);
   ////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl_reg;
   logic [1:0] tracking_time_select_reg;
   logic [7:0] result_low_byte_reg;
   logic [7:0] result_high_byte_reg;
   logic [IRQ_W-1:0] status_reg, status_next;
   logic [IRQ_W-1:0] mask_reg;
   logic [DATA_W-1:0] prdata_reg;
   logic pready_reg, pslverr_reg, irq_reg;
   asc_state_t state_reg, state_next;
   logic [15:0] cnt_reg, cnt_next;
   // Wide enough for the slowest prescaler, presc 7 counting div_reg up to 127
   localparam int DIV_W = 1 << PRESC_W;
   logic [DIV_W-1:0] div_reg;
   logic ck2_reg, switch_reg, slp_started_reg;
   logic [RES_W-1:0] code_reg;
   logic halted_d_reg;

   wire setup = i_psel && !i_penable;
   // Writes land in the access phase, at the edge that sees pready
   wire access = i_psel && i_penable && pready_reg;
   wire wr = access && i_pwrite;
   wire [7:0] off = i_paddr[7:0];
   wire hit_ctrl = off == CTRL_OFF;
   wire hit_ctrl3 = off == CTRL3_OFF;
   wire hit_lo = off == RES_LOW_OFF;
   wire hit_hi = off == RES_HIGH_OFF;
   wire hit_st = off == STATUS_OFF;
   wire hit_mask = off == MASK_OFF;
   wire mapped = hit_ctrl | hit_ctrl3 | hit_lo | hit_hi | hit_st
      | hit_mask;
   wire en = ctrl_reg[CTRL_EN_BIT];
   wire diff = ctrl_reg[CTRL_DIFF_BIT];
   wire left = ctrl_reg[CTRL_LEFT_BIT];
   wire ie = ctrl_reg[CTRL_IE_BIT];
   wire [PRESC_W-1:0] presc = ctrl_reg[CTRL_PRESC_LSB +: PRESC_W];

   ////////////////////////////////////////////////////////////////////
   // Converter clock: tick each 2^presc core clocks, ck2_reg toggling on each tick
   wire [DIV_W-1:0] div_top = DIV_W'((1 << presc) - 1);
   wire adc_tick = en && (div_reg == div_top);
   wire ck2_rise = adc_tick && !ck2_reg;

   // Sleep-start condition on halt edge
   wire sleep_ok = (i_sleep_mode == SLEEP_IDLE)
      || (i_sleep_mode == SLEEP_NOISE);
   wire halt_rise = i_cpu_halted && !halted_d_reg;
   wire sleep_start = halt_rise && sleep_ok && en && ie
      && state_reg == S_IDLE; // [RULE_01]
   wire sw_start = wr && hit_ctrl && i_pstrb[0]
      && i_pwdata[CTRL_START_BIT] && en;
   wire start = (sw_start || sleep_start) && state_reg == S_IDLE;

   // Tracking: field-based clocks, single-ended floored by 500ns in core clocks
   wire [15:0] trk_adc = diff ? 16'(2 * tracking_time_select_reg + 3)
      : 16'(tracking_time_select_reg + 1); // [RULE_07]
   wire [15:0] trk_core = 16'(trk_adc << (presc + 1));
   wire [15:0] trk_len = (!diff && trk_core < 16'(MIN_TRACK_CYC))
      ? 16'(MIN_TRACK_CYC) : trk_core; // [RULE_06]
   wire [15:0] conv_len = 16'(CONV_CLKS << (presc + 1));

   // Result coding with clamp or saturation
   wire signed [11:0] sa = $signed(i_analog_code);
   wire [RES_W-1:0] se_code = (i_analog_code > 12'(SE_MAX)) ? SE_MAX
      : i_analog_code[RES_W-1:0]; // [RULE_10]
   wire [RES_W-1:0] df_code = (sa > 12'sh1FF) ? DIFF_MAX
      : (sa < -12'sh200) ? DIFF_MIN
      : i_analog_code[RES_W-1:0]; // [RULE_11] [RULE_12]
   wire conv_end = state_reg == S_CONV && cnt_next == 16'h0000
      && cnt_reg == 16'h0001;
   wire [15:0] lay = left ? {code_reg, 6'h00}
      : {6'h00, code_reg}; // [RULE_13]

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      if (cnt_reg != 16'h0000) begin
         cnt_next = cnt_reg - 16'h0001;
      end
      case (state_reg)
         S_IDLE: begin
            if (start) begin
               state_next = S_TRACK;
               cnt_next = trk_len;
            end
         end
         S_TRACK: begin
            if (cnt_reg == 16'h0001) begin
               state_next = S_CONV;
               cnt_next = conv_len;
            end
         end
         S_CONV: begin
            if (cnt_reg == 16'h0001) begin
               state_next = S_DONE;
            end
         end
         S_DONE: state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
      if (!en) begin
         state_next = S_IDLE;
         cnt_next = 16'h0000;
      end
   end

   // Set wins over write-one-clear
   always_comb begin
      status_next = status_reg;
      if (wr && hit_st && i_pstrb[0]) begin
         status_next = status_reg & ~i_pwdata[IRQ_W-1:0];
      end
      if (conv_end) begin
         status_next[ST_DONE_BIT] = 1'b1; // [RULE_09] [RULE_03]
         if (slp_started_reg) begin
            status_next[ST_SLEEP_BIT] = 1'b1;
         end
      end
   end

   wire [DATA_W-1:0] rd_mux =
      hit_ctrl ? DATA_W'(ctrl_reg) :
      hit_ctrl3 ? DATA_W'(tracking_time_select_reg) :
      hit_lo ? DATA_W'(result_low_byte_reg) :
      hit_hi ? DATA_W'(result_high_byte_reg) :
      hit_st ? DATA_W'({state_reg != S_IDLE, 5'h00, status_reg}) :
      hit_mask ? DATA_W'(mask_reg) : '0;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         state_reg <= S_IDLE;
         cnt_reg <= 16'h0000;
         status_reg <= '0;
         halted_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         status_reg <= status_next;
         halted_d_reg <= i_cpu_halted;
      end
   end

   // Enable only changes by software, never by sleep entry
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         ctrl_reg <= CTRL_RST;
         tracking_time_select_reg <= 2'h0;
         mask_reg <= '0;
      end else if (wr) begin
         if (hit_ctrl && i_pstrb[0]) begin
            ctrl_reg[7:0] <= i_pwdata[7:0] & ~8'h02; // [RULE_05]
         end
         // Each byte lane writes on its own strobe
         if (hit_ctrl && i_pstrb[1]) begin
            ctrl_reg[15:8] <= i_pwdata[15:8];
         end
         if (hit_ctrl3 && i_pstrb[0]) begin
            tracking_time_select_reg <= i_pwdata[1:0];
         end
         if (hit_mask && i_pstrb[0]) begin
            mask_reg <= i_pwdata[IRQ_W-1:0];
         end
      end
   end

   // Divider and half-period sample clock for the gain stage
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST || !en) begin
         div_reg <= '0;
         ck2_reg <= 1'b0;
      end else begin
         div_reg <= adc_tick ? '0 : div_reg + 1'b1;
         ck2_reg <= adc_tick ? !ck2_reg : ck2_reg; // [RULE_08]
      end
   end

   // Sampling switch and sleep-start marker
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         switch_reg <= 1'b0;
         slp_started_reg <= 1'b0;
         code_reg <= '0;
      end else begin
         switch_reg <= state_next == S_TRACK && (!diff || ck2_reg);
         if (start) begin
            slp_started_reg <= sleep_start;
         end
         if (state_reg == S_TRACK && cnt_reg == 16'h0001) begin
            code_reg <= diff ? df_code : se_code;
         end
      end
   end

   // Both bytes load in one edge, but nothing locks them between the low and the high byte read
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         result_low_byte_reg <= 8'h00;
         result_high_byte_reg <= 8'h00;
      end else if (state_reg == S_DONE || (state_reg == S_IDLE
            && wr && hit_ctrl)) begin
         result_low_byte_reg <= lay[7:0]; // [RULE_14] [RULE_13]
         result_high_byte_reg <= lay[15:8];
      end
   end

   // APB slave: one wait-free access phase
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup && !mapped;
         prdata_reg <= (setup && !i_pwrite) ? rd_mux : '0;
         // Wake comes from the level; CPU stays awake by itself
         // One cycle behind the flags, so a clear never races the level
         irq_reg <= |(status_reg & mask_reg); // [RULE_02] [RULE_04]
      end
   end

   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_irq = irq_reg;
   assign o_converter_enable = ctrl_reg[CTRL_EN_BIT];
   assign o_sample_switch = switch_reg;
   assign o_secondary_conversion_clock = ck2_reg;
   assign o_busy = halted_d_reg;

   ////////////////////////////////////////////////////////////////////
   a_sleep_start: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) sleep_start |=> state_reg == S_TRACK)
      else $error("sleep start missed"); // [RULE_01]
   a_done_flag: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) conv_end |=> status_reg[ST_DONE_BIT])
      else $error("done flag not set"); // [RULE_09]
   a_track_min: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (start && !diff) |=> cnt_reg >= 16'd50)
      else $error("tracking too short"); // [RULE_06]
   a_irq_level: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) |(status_reg & mask_reg) |=> o_irq)
      else $error("irq not raised"); // [RULE_02]
   a_enable_kept: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (en && !(wr && hit_ctrl)) |=> en)
      else $error("enable dropped"); // [RULE_05]
   a_res_stable: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (state_reg == S_CONV)
      |=> $stable(result_high_byte_reg))
      else $error("result changed early"); // [RULE_14]
   a_se_clamp: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (i_analog_code > 12'h3FF && !sa[11])
      |-> se_code == SE_MAX)
      else $error("clamp wrong"); // [RULE_10]
   a_left_adj: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (state_reg == S_DONE && left)
      |=> result_high_byte_reg == $past(code_reg[9:2]))
      else $error("left adjust wrong"); // [RULE_13]
   a_df_high: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (sa > 12'sh1FF) |-> df_code == DIFF_MAX)
      else $error("positive saturation wrong"); // [RULE_11]
   a_df_low: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (sa < -12'sh200) |-> df_code == DIFF_MIN)
      else $error("negative saturation wrong"); // [RULE_11]
   a_sign_place: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (state_reg == S_DONE && diff && !left)
      |=> result_high_byte_reg[1] == $past(code_reg[9]))
      else $error("sign bit misplaced"); // [RULE_12]
   a_right_adj: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (state_reg == S_DONE && !left)
      |=> result_low_byte_reg == $past(code_reg[7:0]))
      else $error("right adjust wrong"); // [RULE_13]
   a_diff_switch: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (o_sample_switch && diff)
      |-> $past(ck2_reg))
      else $error("gain sample outside half period"); // [RULE_08]
   a_pready_once: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) o_pready |=> !o_pready)
      else $error("pready held too long");
   a_irq_quiet: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) !(|(status_reg & mask_reg)) |=> !o_irq)
      else $error("irq without flag"); // [RULE_02]
   a_sleep_flag: assert property (@(posedge I_CORE_CLK)
      disable iff (I_SYS_RST) (conv_end && slp_started_reg)
      |=> status_reg[ST_SLEEP_BIT])
      else $error("sleep done flag missed"); // [RULE_03]
   c_sleep_conv: cover property (@(posedge I_CORE_CLK) sleep_start);
   c_sleep_done: cover property (@(posedge I_CORE_CLK)
      conv_end && slp_started_reg);
   c_left_conv: cover property (@(posedge I_CORE_CLK) conv_end && left);
   c_diff_conv: cover property (@(posedge I_CORE_CLK) conv_end && diff);
   c_irq: cover property (@(posedge I_CORE_CLK) o_irq);
endmodule : asc_conv_ctrl
`default_nettype wire

// [verification/asc_cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Sleep controller and core stand-in
module asc_cpu_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic irq,
   input wire logic sleep_req,
   input wire logic [2:0] mode_req,
   input wire logic wake_other,
   output logic halted,
   output logic [2:0] sleep_mode
);
   always_ff @(posedge clk) begin
      if (rst) begin
         halted <= 1'b0;
         sleep_mode <= 3'h0;
      end else if (halted && (irq || wake_other)) begin
         // Awake until the next request, never back on its own
         halted <= 1'b0;
      end else if (sleep_req) begin
         halted <= 1'b1;
         sleep_mode <= mode_req;
      end
   end
endmodule : asc_cpu_model
`default_nettype wire

// [verification/asc_conv_ctrl_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module asc_conv_ctrl_tb;
   import asc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] paddr = 32'h0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [11:0] code = 12'h000;
   logic sreq = 1'b0;
   logic [2:0] mreq = 3'h0;
   logic wake = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, halted, en, sw, sclk;
   logic [2:0] smode;
   logic [31:0] rd;
   logic err;
   int fails = 0;
   int checked = 0;
   int trk = 0;
   ////////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (sw === 1'b1) trk <= trk + 1;
   end
   asc_conv_ctrl asc_conv_ctrl_inst (.I_CORE_CLK(clk), .I_SYS_RST(rst),
      .i_paddr(paddr), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_pwdata(pwdata), .i_pstrb(4'hF), .i_cpu_halted(halted),
      .i_sleep_mode(smode), .i_analog_code(code), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq),
      .o_converter_enable(en), .o_sample_switch(sw),
      .o_secondary_conversion_clock(sclk), .o_busy());
   asc_cpu_model asc_cpu_model_inst (.clk(clk), .rst(rst), .irq(irq),
      .sleep_req(sreq), .mode_req(mreq), .wake_other(wake),
      .halted(halted), .sleep_mode(smode));
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Waits on pready itself; the slave latency is not assumed
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task poll(input int lim);
      int n;
      n = 0;
      do begin
         apb(1'b0, STATUS_OFF, 32'h0);
         n++;
      end while (rd[ST_DONE_BIT] !== 1'b1 && n < lim);
   endtask : poll
   task conv(input logic [31:0] c, input logic [11:0] v,
      input logic [15:0] exp, input int t);
      logic [7:0] lo;
      code <= v;
      trk = 0;
      apb(1'b1, CTRL_OFF, c);
      apb(1'b1, CTRL_OFF, c | 32'h2);
      poll(300);
      chk(16'(irq), 16'h1);
      apb(1'b0, RES_LOW_OFF, 32'h0);
      lo = rd[7:0];
      apb(1'b0, RES_HIGH_OFF, 32'h0);
      chk({rd[7:0], lo}, exp);
      if (t > 0) chk(16'(trk >= t), 16'h1);
      apb(1'b1, STATUS_OFF, 32'h1);
      repeat (2) @(posedge clk);
      chk(16'(irq), 16'h0);
      $display("conv %h done", v);
   endtask : conv
   ////////////////////////////////////////////////////////////////////////
   task test_regs;
      apb(1'b0, CTRL_OFF, 32'h0);
      chk(rd[15:0], 16'h0);
      apb(1'b0, STATUS_OFF, 32'h0);
      chk(rd[15:0], 16'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(16'(err), 16'h1);
      apb(1'b1, MASK_OFF, 32'h3);
      apb(1'b0, MASK_OFF, 32'h0);
      chk(rd[15:0], 16'h3);
      $display("test_regs done");
   endtask : test_regs
   task test_results;
      conv(32'h1, 12'h2A5, 16'h02A5, 50);
      conv(32'h1, 12'h5FF, 16'h03FF, 50);
      conv(32'h5, 12'h2A5, 16'hA940, 50);
      conv(32'h9, 12'hE70, 16'h0270, 0);
      conv(32'hD, 12'hE70, 16'h9C00, 0);
      conv(32'h9, 12'h800, 16'h0200, 0);
      conv(32'h9, 12'h7FF, 16'h01FF, 0);
      apb(1'b1, CTRL3_OFF, 32'h3);
      conv(32'h401, 12'h001, 16'h0001, 128);
      apb(1'b1, CTRL3_OFF, 32'h0);
      $display("test_results done");
   endtask : test_results
   task sleep_run(input logic [2:0] m, input logic o, input logic [15:0] e);
      code <= 12'h123;
      apb(1'b1, CTRL_OFF, 32'h11);
      mreq <= m;
      sreq <= 1'b1;
      @(posedge clk);
      sreq <= 1'b0;
      repeat (4) @(posedge clk);
      wake <= o;
      @(posedge clk);
      wake <= 1'b0;
      poll(60);
      apb(1'b0, STATUS_OFF, 32'h0);
      chk(rd[15:0], e);
      chk(16'(halted), 16'h0);
      chk(16'(en), 16'h1);
      apb(1'b1, STATUS_OFF, 32'h3);
      $display("sleep mode %h done", m);
   endtask : sleep_run
   task test_sleep;
      sleep_run(SLEEP_NOISE, 1'b0, 16'h3);
      sleep_run(SLEEP_IDLE, 1'b1, 16'h3);
      sleep_run(3'h2, 1'b1, 16'h0);
   endtask : test_sleep
   ////////////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      test_regs;
      test_results;
      test_sleep;
      print_verdict;
   end
   // Over thirty times the expected run length
   initial begin
      #500000;
      fails++;
      print_verdict;
   end
endmodule : asc_conv_ctrl_tb
`default_nettype wire
